//--- design/hcr_pkg.sv
package hcr_pkg;

    // Register offsets of this bank
    localparam logic [7:0] HCR_OFF_POWER_SPEED  = 8'h07;
    localparam logic [7:0] HCR_OFF_POWER_SWITCH = 8'h08;
    localparam logic [7:0] HCR_OFF_FIXED_ATTACH = 8'h09;
    localparam logic [7:0] HCR_OFF_SELF_OFF     = 8'h0a;
    localparam logic [7:0] HCR_OFF_BUS_OFF      = 8'h0b;
    localparam logic [7:0] HCR_OFF_SELF_DRAW    = 8'h0c;

    // Range guarded by the configuration lock
    localparam logic [7:0] HCR_LOCK_LO = 8'h01;
    localparam logic [7:0] HCR_LOCK_HI = 8'h10;

    // Reset value of every register
    localparam logic [7:0] HCR_RESET_VAL = 8'h00;

    // Field positions, power_speed_config
    localparam int HCR_BIT_POWER_SOURCE = 7;
    localparam int HCR_BIT_FS_ONLY      = 5;
    localparam int HCR_BIT_EOP_SUPPRESS = 3;
    localparam int HCR_BIT_OC_MODE_HI   = 2;
    localparam int HCR_BIT_OC_MODE_LO   = 1;
    // Writable bits
    localparam logic [7:0] HCR_MASK_POWER_SPEED  = 8'hae;
    localparam logic [7:0] HCR_MASK_POWER_SWITCH = 8'hb8;
    localparam logic [7:0] HCR_MASK_PORTS        = 8'h06;

    // Field positions, power_switch_config
    localparam int HCR_BIT_DYNAMIC  = 7;
    localparam int HCR_BIT_OC_DLY_HI = 5;
    localparam int HCR_BIT_OC_DLY_LO = 4;
    localparam int HCR_BIT_COMPOUND = 3;

    // Over-current sense encodings
    typedef enum logic [1:0] {
        HCR_OC_GANGED   = 2'h0,
        HCR_OC_RESERVED = 2'h1,
        HCR_OC_NONE_A   = 2'h2,
        HCR_OC_NONE_B   = 2'h3
    } hcr_oc_mode_t;

    // Clock rate and over-current delays
    localparam int HCR_CLK_MHZ    = 125;
    localparam int HCR_OC_US_0    = 100;
    localparam int HCR_OC_US_1    = 2000;
    localparam int HCR_OC_US_2    = 4000;
    localparam int HCR_OC_US_3    = 6000;
    localparam int HCR_OC_CYC_0   = HCR_OC_US_0 * HCR_CLK_MHZ;
    localparam int HCR_OC_CYC_1   = HCR_OC_US_1 * HCR_CLK_MHZ;
    localparam int HCR_OC_CYC_2   = HCR_OC_US_2 * HCR_CLK_MHZ;
    localparam int HCR_OC_CYC_3   = HCR_OC_US_3 * HCR_CLK_MHZ;

    // Upstream draw unit in mA per count
    localparam int HCR_DRAW_UNIT_MA = 2;

endpackage

//--- design/hcr_overcurrent_delay_select.sv
`timescale 1ns/100ps
// Over-current qualifier: fault must persist for the selected delay
module hcr_overcurrent_delay_select #(
    parameter int CYC_0 = 12500,
    parameter int CYC_1 = 250000,
    parameter int CYC_2 = 500000,
    parameter int CYC_3 = 750000
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // Control
    input  wire logic       enable_i,
    input  wire logic [1:0] delay_sel_i,
    input  wire logic       fault_i,
    // Result
    output logic            tripped_o
);
    logic [19:0] count_r;
    logic [19:0] limit;
    logic        armed;

    // Delay selection
    assign limit = (delay_sel_i == 2'h0) ? 20'(CYC_0) :
                   (delay_sel_i == 2'h1) ? 20'(CYC_1) :
                   (delay_sel_i == 2'h2) ? 20'(CYC_2) : 20'(CYC_3);
    assign armed = enable_i && fault_i;

    // Count while fault persists, trip at the limit
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !armed) begin
            count_r   <= 20'h00000;
            tripped_o <= 1'b0;
        end else if (count_r >= limit - 20'h00001) begin
            tripped_o <= 1'b1;
        end else begin
            count_r <= count_r + 20'h00001;
        end
    end
endmodule // hcr_overcurrent_delay_select

//--- design/hcr_config_regs.sv
`timescale 1ns/100ps
// Summary of operation
// - Power-speed bit 7 picks self-powered or bus-powered operation.
// - With dynamic switching on, local power pin decides power source.
// - Power-speed bit 5 set forces full-speed-only attachment.
// - Power-speed bit 3 set suppresses full-speed end-of-packet at EOF1.
// - Sense field 00 ganged, 01 reserved, 1x sensing not supported.
// - Switch bit 7 enables fallback to bus power and return to self.
// - Delay field selects 0.1, 2, 4 or 6 ms over-current delay.
// - Switch bit 3 marks the hub as part of a compound device.
// - Fixed-attach bits 1 and 2 mark ports non-removable; rest zero.
// - Self-powered off mask bits 1, 2 disable ports in self power.
// - Bus-powered off mask bits 1, 2 disable ports in bus power.
// - Upstream draw byte counts 2 mA units; 50 means 100 mA.
// - All registers in this bank reset to zero.
// - Once locked, writes to 01h through 10h are refused until reset.
module hcr_config_regs #(
    parameter int OC_CYC_0 = hcr_pkg::HCR_OC_CYC_0,
    parameter int OC_CYC_1 = hcr_pkg::HCR_OC_CYC_1,
    parameter int OC_CYC_2 = hcr_pkg::HCR_OC_CYC_2,
    parameter int OC_CYC_3 = hcr_pkg::HCR_OC_CYC_3
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // Register access from the serial slave
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic [7:0]      reg_rdata_o,
    input  wire logic       config_lock_i,
    // Hub pins and status
    input  wire logic       local_power_sense_pin_i,
    input  wire logic       overcurrent_fault_i,
    // Controls to the hub core
    output logic            self_powered_o,
    output logic            full_speed_only_o,
    output logic            end_packet_suppress_o,
    output logic            overcurrent_sense_on_o,
    output logic            overcurrent_ganged_o,
    output logic            overcurrent_trip_o,
    output logic            compound_device_o,
    output logic [1:0]      fixed_attach_ports_o,
    output logic [1:0]      port_off_o,
    output logic [7:0]      upstream_draw_o
);
    logic [7:0] power_speed_config_r;
    logic [7:0] power_switch_config_r;
    logic [7:0] fixed_attach_port_mask_r;
    logic [7:0] self_powered_port_off_mask_r;
    logic [7:0] bus_powered_port_off_mask_r;
    logic [7:0] self_powered_upstream_draw_r;
    logic       lock_r;
    logic [7:0] rdata_nxt;
    logic       self_mode_nxt;
    logic       oc_trip;

    // Lock gating and address decode
    wire locked_range = (reg_addr_i >= hcr_pkg::HCR_LOCK_LO) &&
                        (reg_addr_i <= hcr_pkg::HCR_LOCK_HI);
    wire wr_ok        = reg_wr_i && !(lock_r && locked_range);
    wire wr_ps = wr_ok && (reg_addr_i == hcr_pkg::HCR_OFF_POWER_SPEED);
    wire wr_sw = wr_ok && (reg_addr_i == hcr_pkg::HCR_OFF_POWER_SWITCH);
    wire wr_fa = wr_ok && (reg_addr_i == hcr_pkg::HCR_OFF_FIXED_ATTACH);
    wire wr_so = wr_ok && (reg_addr_i == hcr_pkg::HCR_OFF_SELF_OFF);
    wire wr_bo = wr_ok && (reg_addr_i == hcr_pkg::HCR_OFF_BUS_OFF);
    wire wr_sd = wr_ok && (reg_addr_i == hcr_pkg::HCR_OFF_SELF_DRAW);

    // Field extraction
    wire dynamic_on  = power_switch_config_r[hcr_pkg::HCR_BIT_DYNAMIC];
    wire mode_bit    = power_speed_config_r[hcr_pkg::HCR_BIT_POWER_SOURCE];
    wire [1:0] oc_mode = power_speed_config_r[hcr_pkg::HCR_BIT_OC_MODE_HI:
                                              hcr_pkg::HCR_BIT_OC_MODE_LO];
    wire [1:0] oc_dly  = power_switch_config_r[hcr_pkg::HCR_BIT_OC_DLY_HI:
                                               hcr_pkg::HCR_BIT_OC_DLY_LO];
    wire oc_sensing  = !oc_mode[1];
    wire oc_ganged   = (oc_mode == hcr_pkg::HCR_OC_GANGED);
    wire eop_off_bit = power_speed_config_r[hcr_pkg::HCR_BIT_EOP_SUPPRESS];

    // Power source: dynamic switching follows the local power pin
    assign self_mode_nxt = dynamic_on ? local_power_sense_pin_i
                                      : mode_bit;

    // Readback mux; undefined offsets return zero
    always_comb begin
        case (reg_addr_i)
            hcr_pkg::HCR_OFF_POWER_SPEED:  rdata_nxt = power_speed_config_r;
            hcr_pkg::HCR_OFF_POWER_SWITCH: rdata_nxt = power_switch_config_r;
            hcr_pkg::HCR_OFF_FIXED_ATTACH: rdata_nxt = fixed_attach_port_mask_r;
            hcr_pkg::HCR_OFF_SELF_OFF:     rdata_nxt = self_powered_port_off_mask_r;
            hcr_pkg::HCR_OFF_BUS_OFF:      rdata_nxt = bus_powered_port_off_mask_r;
            hcr_pkg::HCR_OFF_SELF_DRAW:    rdata_nxt = self_powered_upstream_draw_r;
            default:                       rdata_nxt = 8'h00;
        endcase
    end

    // Over-current delay qualifier
    hcr_overcurrent_delay_select #(
        .CYC_0 (OC_CYC_0),
        .CYC_1 (OC_CYC_1),
        .CYC_2 (OC_CYC_2),
        .CYC_3 (OC_CYC_3)
    ) u_overcurrent_delay_select (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .enable_i    (oc_sensing),
        .delay_sel_i (oc_dly),
        .fault_i     (overcurrent_fault_i),
        .tripped_o   (oc_trip)
    );

    // Register storage; reserved bits are held at zero
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            power_speed_config_r         <= hcr_pkg::HCR_RESET_VAL;
            power_switch_config_r        <= hcr_pkg::HCR_RESET_VAL;
            fixed_attach_port_mask_r     <= hcr_pkg::HCR_RESET_VAL;
            self_powered_port_off_mask_r <= hcr_pkg::HCR_RESET_VAL;
            bus_powered_port_off_mask_r  <= hcr_pkg::HCR_RESET_VAL;
            self_powered_upstream_draw_r <= hcr_pkg::HCR_RESET_VAL;
        end else begin
            if (wr_ps) begin
                power_speed_config_r <= reg_wdata_i & hcr_pkg::HCR_MASK_POWER_SPEED;
            end
            if (wr_sw) begin
                power_switch_config_r <= reg_wdata_i & hcr_pkg::HCR_MASK_POWER_SWITCH;
            end
            if (wr_fa) begin
                fixed_attach_port_mask_r <= reg_wdata_i & hcr_pkg::HCR_MASK_PORTS;
            end
            if (wr_so) begin
                self_powered_port_off_mask_r <= reg_wdata_i & hcr_pkg::HCR_MASK_PORTS;
            end
            if (wr_bo) begin
                bus_powered_port_off_mask_r <= reg_wdata_i & hcr_pkg::HCR_MASK_PORTS;
            end
            if (wr_sd) begin
                self_powered_upstream_draw_r <= reg_wdata_i;
            end
        end
    end

    // Lock is sticky until reset
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            lock_r <= 1'b0;
        end else if (config_lock_i) begin
            lock_r <= 1'b1;
        end
    end

    // Registered outputs to the hub core
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o            <= 8'h00;
            self_powered_o         <= 1'b0;
            full_speed_only_o      <= 1'b0;
            end_packet_suppress_o  <= 1'b0;
            overcurrent_sense_on_o <= 1'b0;
            overcurrent_ganged_o   <= 1'b0;
            overcurrent_trip_o     <= 1'b0;
            compound_device_o      <= 1'b0;
            fixed_attach_ports_o   <= 2'h0;
            port_off_o             <= 2'h0;
            upstream_draw_o        <= 8'h00;
        end else begin
            reg_rdata_o            <= rdata_nxt;
            self_powered_o         <= self_mode_nxt;
            full_speed_only_o      <= power_speed_config_r[hcr_pkg::HCR_BIT_FS_ONLY];
            end_packet_suppress_o  <= eop_off_bit;
            overcurrent_sense_on_o <= oc_sensing;
            overcurrent_ganged_o   <= oc_ganged;
            overcurrent_trip_o     <= oc_trip;
            compound_device_o      <= power_switch_config_r[hcr_pkg::HCR_BIT_COMPOUND];
            fixed_attach_ports_o   <= fixed_attach_port_mask_r[2:1];
            port_off_o             <= self_mode_nxt ? self_powered_port_off_mask_r[2:1]
                                                    : bus_powered_port_off_mask_r[2:1];
            upstream_draw_o        <= self_powered_upstream_draw_r;
        end
    end
endmodule // hcr_config_regs

//--- tb/hcr_config_regs_chk.sv
`timescale 1ns/100ps
// Port-level checks of the configuration bank
module hcr_config_regs_chk (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       reset_n_i,
    // Register port and lock
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       config_lock_i,
    // Pins and controls
    input wire logic       overcurrent_fault_i,
    input wire logic       full_speed_only_o,
    input wire logic       end_packet_suppress_o,
    input wire logic       overcurrent_sense_on_o,
    input wire logic       overcurrent_ganged_o,
    input wire logic       overcurrent_trip_o,
    input wire logic       compound_device_o,
    input wire logic [7:0] upstream_draw_o
);
    logic lk_r;
    // Sticky copy of the lock; a write is open only while it is clear
    always_ff @(posedge clk_i) begin
        lk_r <= reset_n_i & (lk_r | config_lock_i);
    end
    wire open_wr = reg_wr_i & ~lk_r & ~config_lock_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_fs_only_wr:
    assert property (open_wr && reg_addr_i == 8'h07 |-> ##2
        full_speed_only_o == $past(reg_wdata_i[5], 2)) else $error("full-speed flag missed write");
    a_draw_wr:
    assert property (open_wr && reg_addr_i == 8'h0c |=> ##1
        upstream_draw_o == $past(reg_wdata_i, 2)) else $error("upstream draw missed write");
    a_lock_hold:
    assert property (lk_r && $past(lk_r, 3) |-> $stable(full_speed_only_o)
        && $stable(compound_device_o) && $stable(upstream_draw_o))
        else $error("locked bank changed");
    a_reset_zero:
    assert property ($rose(reset_n_i) |-> reg_rdata_o == 8'h00 && !full_speed_only_o
        && !compound_device_o && upstream_draw_o == 8'h00) else $error("reset value not zero");
    a_port_resv:
    assert property (reg_addr_i inside {8'h09, 8'h0a, 8'h0b} |=> (reg_rdata_o & 8'hf9) == 8'h00)
        else $error("reserved port bit read as one");
    a_cfg1_match:
    assert property (reg_addr_i == 8'h07 |=> end_packet_suppress_o == reg_rdata_o[3]
        && overcurrent_ganged_o == (reg_rdata_o[2:1] == 2'h0)
        && overcurrent_sense_on_o == !reg_rdata_o[2]) else $error("first byte controls differ");
    a_power_switch_config_match:
    assert property (reg_addr_i == 8'h08 |=> compound_device_o == reg_rdata_o[3])
        else $error("compound flag differs");
    a_trip_cause:
    assert property ($rose(overcurrent_trip_o) |-> $past(overcurrent_fault_i, 6)
        && $past(overcurrent_sense_on_o)) else $error("trip without held fault");
    a_trip_drop:
    assert property (!overcurrent_fault_i [*3] |-> !overcurrent_trip_o)
        else $error("trip stayed after fault cleared");
endmodule // hcr_config_regs_chk
bind hcr_config_regs hcr_config_regs_chk u_chk (.clk_i, .reset_n_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rdata_o, .config_lock_i, .overcurrent_fault_i, .full_speed_only_o,
    .end_packet_suppress_o, .overcurrent_sense_on_o, .overcurrent_ganged_o,
    .overcurrent_trip_o, .compound_device_o, .upstream_draw_o);

//--- tb/hcr_host_model.sv
`timescale 1ns/100ps
// Configuring party: byte writes and reads, driven on the falling edge
module hcr_host_model (
    // Clock
    input  wire logic       clk_i,
    // Register port
    input  wire logic [7:0] reg_rdata_i,
    output logic [7:0]      reg_addr_o = 8'h00,
    output logic            reg_wr_o = 1'b0,
    output logic [7:0]      reg_wdata_o = 8'h00
);
    // Polite writes keep reserved bits zero and the draw limit
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit pol,
                      output logic [7:0] sent);
        sent = d;
        if (pol) begin
            sent = sent & (a == 8'h07 ? 8'hae : a == 8'h08 ? 8'hb8 :
                           a == 8'h0c ? 8'hff : 8'h06);
            if (a == 8'h0c && sent > 8'h32) sent = 8'h32;
            if (a == 8'h07 && sent[2]) sent[7] = 1'b0;
        end
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = sent;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~sent;
    endtask
    // Read: offset on one falling edge, data taken on the next
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask
endmodule // hcr_host_model

//--- tb/hub_config_registers_tb.sv
`timescale 1ns/100ps
// Self-checking bench of the hub configuration bank
module hub_config_registers_tb;
    logic clk_i = 1'b0, reset_n_i = 1'b0, config_lock_i = 1'b0;
    logic local_power_sense_pin_i = 1'b0, overcurrent_fault_i = 1'b0;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, upstream_draw_o, a, s, got;
    logic reg_wr_i, self_powered_o, full_speed_only_o, end_packet_suppress_o, compound_device_o;
    logic overcurrent_sense_on_o, overcurrent_ganged_o, overcurrent_trip_o;
    logic [1:0] fixed_attach_ports_o, port_off_o;
    logic [17:0] exp_v;
    logic [7:0] sh [7:12];
    int errors = 0, tests_run = 0, n, seed = 32'h877cfe41, cyc [4] = '{5, 10, 15, 20};
    wire [17:0] outs = {self_powered_o, full_speed_only_o, end_packet_suppress_o,
        overcurrent_sense_on_o, overcurrent_ganged_o, compound_device_o, fixed_attach_ports_o,
        port_off_o, upstream_draw_o};
    // Clock and instances
    always #4 clk_i = ~clk_i;
    hcr_config_regs #(.OC_CYC_0(5), .OC_CYC_1(10), .OC_CYC_2(15), .OC_CYC_3(20)) dut (
        .clk_i, .reset_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .config_lock_i,
        .local_power_sense_pin_i, .overcurrent_fault_i, .self_powered_o, .full_speed_only_o,
        .end_packet_suppress_o, .overcurrent_sense_on_o, .overcurrent_ganged_o,
        .overcurrent_trip_o, .compound_device_o, .fixed_attach_ports_o, .port_off_o,
        .upstream_draw_o);
    hcr_host_model host (.clk_i, .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
    // Compare, count and report
    task automatic check(input logic [17:0] g, input logic [17:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [7:0] mask(input logic [7:0] x);
        return x == 8'h07 ? 8'hae : x == 8'h08 ? 8'hb8 : x == 8'h0c ? 8'hff : 8'h06;
    endfunction
    // Expected controls from the shadow registers and the power pin
    function automatic logic [17:0] exp_out(input logic pin);
        logic sp;
        sp = sh[8][7] ? pin : sh[7][7];
        return {sp, sh[7][5], sh[7][3], ~sh[7][2], sh[7][2:1] == 2'h0, sh[8][3], sh[9][2:1],
            sp ? sh[10][2:1] : sh[11][2:1], sh[12]};
    endfunction
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #(8 * 20000);
        errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (6) @(negedge clk_i);
        reset_n_i = 1'b1;
        for (int i = 7; i <= 12; i++) begin
            host.rd(8'(i), got);
            check({10'h0, got}, 18'h0);
            sh[i] = 8'h00;
        end
        $display("Reset values test done");
        for (int i = 0; i < 60; i++) begin
            a = 8'h07 + 8'($unsigned($random(seed)) % 6);
            local_power_sense_pin_i = 1'($random(seed));
            host.wr(a, 8'($random(seed)), i[0], s);
            sh[a] = s & mask(a);
            host.rd(a, got);
            check({10'h0, got}, {10'h0, sh[a]});
            exp_v = exp_out(local_power_sense_pin_i);
            check(outs & 18'h20300, exp_v & 18'h20300);
            check(outs & 18'h1fcff, exp_v & 18'h1fcff);
        end
        $display("Random write test done");
        host.wr(8'h07, 8'h00, 1'b1, s);
        for (int k = 0; k < 4; k++) begin
            host.wr(8'h08, {2'h0, 2'(k), 4'h0}, 1'b1, s);
            overcurrent_fault_i = 1'b1;
            n = 0;
            while (overcurrent_trip_o !== 1'b1 && n < 100) begin
                @(negedge clk_i);
                n++;
            end
            check({17'h0, n >= cyc[k] + 1 && n <= cyc[k] + 3}, 18'h1);
            overcurrent_fault_i = 1'b0;
            repeat (4) @(negedge clk_i);
        end
        host.wr(8'h07, 8'h84, 1'b1, s);
        overcurrent_fault_i = 1'b1;
        repeat (30) @(negedge clk_i);
        check({17'h0, overcurrent_trip_o}, 18'h0);
        overcurrent_fault_i = 1'b0;
        $display("Over-current test done");
        config_lock_i = 1'b1;
        @(negedge clk_i);
        config_lock_i = 1'b0;
        host.wr(8'h07, 8'h20, 1'b1, s);
        host.rd(8'h07, got);
        check({10'h0, got}, 18'h04);
        reset_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        reset_n_i = 1'b1;
        host.wr(8'h0c, 8'h32, 1'b1, s);
        host.rd(8'h07, got);
        check({2'h0, got, upstream_draw_o}, {10'h0, 8'h32});
        $display("Lock test done");
        end_of_test();
    end
endmodule // hub_config_registers_tb
